// >>> core/gpio_line_map.svh
// register offsets, line count, source field width and reset values of the camera line controller
// assumes: included by the package user modules, apb byte addressing
`ifndef GPIO_LINE_MAP_SVH
`define GPIO_LINE_MAP_SVH

`define LINE_COUNT 4
`define OFS_LINE_INDEX_SELECT 12'h000
`define OFS_LINE_DIRECTION 12'h004
`define OFS_LINE_POLARITY_INVERT 12'h008
`define OFS_LINE_OUTPUT_SOURCE 12'h00c
`define OFS_LINE_LEVEL 12'h010
`define OFS_ALL_LINE_LEVELS 12'h014
`define OFS_AUX_RAIL_ENABLE 12'h018
`define SRC_WIDTH 3
`define RST_DIRECTION 1'h0
`define RST_INVERT 1'h0
`define RST_SOURCE 3'h0
`define RST_AUX_RAIL 1'h0
`define RST_SELECT 2'h0

`endif

// >>> core/gpio_line_pkg.sv
// types shared by the camera line controller modules
// assumes: gpio_line_map.svh sits in the include path
`include "gpio_line_map.svh"
package gpio_line_pkg;
	// output source choices in documented order
	typedef enum logic [2:0] {
		SRC_OFF,
		SRC_LINE0,
		SRC_LINE1,
		SRC_LINE2,
		SRC_LINE3,
		SRC_EXPOSING,
		SRC_TRIG_READY,
		SRC_SERIAL_TX
	} line_src_e;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_ACCESS
	} bus_state_e;

	typedef struct packed {
		logic [3:0] dirOut;
		logic [3:0] invert;
		logic [3:0][2:0] source;
	} line_cfg_s;
endpackage

// >>> core/line_cfg_store.sv
// per-line configuration store: direction, inversion and output source for all four lines
// assumes: one write port addressed by the line selector, all lines readable in parallel
`timescale 1ns/10ps
module line_cfg_store
	import gpio_line_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic ce, // clock enable
	input wire logic wrDir, // write direction of selected line
	input wire logic wrInv, // write inversion of selected line
	input wire logic wrSrc, // write source of selected line
	input wire logic [1:0] sel, // selected line
	input wire logic [31:0] wdata, // write data
	output line_cfg_s cfg // registered configuration
);
	typedef struct packed {
		line_cfg_s cfg;
	} store_s;

	store_s cur_ff;
	store_s nxt_cur;

	assign cfg = cur_ff.cfg;

	// update only the selected line's fields
	always_comb begin
		nxt_cur = cur_ff;
		if (wrDir) begin
			nxt_cur.cfg.dirOut[sel] = wdata[0];
		end
		if (wrInv) begin
			nxt_cur.cfg.invert[sel] = wdata[0];
		end
		if (wrSrc) begin
			nxt_cur.cfg.source[sel] = wdata[2:0];
		end
	end

	// input, no inversion, source off after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_ff.cfg.dirOut <= {`LINE_COUNT{`RST_DIRECTION}};
			cur_ff.cfg.invert <= {`LINE_COUNT{`RST_INVERT}};
			cur_ff.cfg.source <= {`LINE_COUNT{`RST_SOURCE}};
		end else if (ce) begin
			cur_ff <= nxt_cur;
		end
	end
endmodule

// >>> core/line_drive.sv
// pin-side datapath: builds each line's drive value and enable, and its logical level
// assumes: pin inputs synchronous to clk, outputs registered by the caller
`timescale 1ns/10ps
module line_drive
	import gpio_line_pkg::*;
(
	input line_cfg_s cfg, // line configuration
	input wire logic [3:0] pinIn, // pin levels seen at the connector
	input wire logic sensorExposingFlag, // sensor exposing
	input wire logic triggerReadyFlag, // ready for frame start trigger
	input wire logic serialTxSource, // serial transmit data
	output logic [3:0] driveVal, // value to put on each pin
	output logic [3:0] driveEn, // drive enable per pin
	output logic [3:0] level // logical level of each line after inversion
);
	// chosen internal signal for one source code
	function automatic logic pickSource(input logic [2:0] code, input logic [3:0] lv,
		input logic expo, input logic trig, input logic tx);
		logic r;
		r = 1'b0;
		case (line_src_e'(code))
			SRC_LINE0: r = lv[0];
			SRC_LINE1: r = lv[1];
			SRC_LINE2: r = lv[2];
			SRC_LINE3: r = lv[3];
			SRC_EXPOSING: r = expo;
			SRC_TRIG_READY: r = trig;
			SRC_SERIAL_TX: r = tx;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < `LINE_COUNT; gi++) begin : g_line
			// level seen inside is the pin level through the inverter
			assign level[gi] = pinIn[gi] ^ cfg.invert[gi];
			// drive only in output mode and when a source is chosen
			assign driveEn[gi] = cfg.dirOut[gi] && (cfg.source[gi] != `RST_SOURCE);
			// source value inverted on the way out
			assign driveVal[gi] = pickSource(cfg.source[gi], level, sensorExposingFlag,
				triggerReadyFlag, serialTxSource) ^ cfg.invert[gi];
		end
	endgenerate
endmodule

// >>> core/camera_gpio_line_control.sv
// top of the camera line controller: apb register slave plus four connector lines
// assumes: apb master on clk, pins already synchronous to clk, pads resolve from enables
//
// How it works
// - four lines; a selector picks which line the per-line settings address
// - each line has input or output direction; driven only when output
// - inversion flips the selected line's signal in both directions
// - single-line level reads one when the selected line is high after its inverter
// - all-lines word gives line n level at bit n
// - output source acts only while the line is an output
// - a line source copies another line's level, a loop back
// - exposing and trigger-ready flags can be driven as sources
// - read-write bit switches the auxiliary rail onto the connector
// - any line can carry serial transmit as its source; line 1's level is serial receive
// - serial reaches a pin only as a source; off drives nothing
`timescale 1ns/10ps
module camera_gpio_line_control
	import gpio_line_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic ce, // clock enable, freezes state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error for unmapped address
	input wire logic [3:0] lineIn, // connector line pin inputs
	output logic [3:0] lineOut, // connector line pin output values
	output logic [3:0] lineOe, // connector line output enables, high drives
	input wire logic sensorExposingFlag, // sensor exposing
	input wire logic triggerReadyFlag, // camera ready for frame start trigger
	input wire logic serialTxSource, // serial transmit data
	output logic serialRxData, // serial receive data taken from line 1
	output logic auxRailEnable // auxiliary 3.3v rail switch
);
	typedef struct packed {
		bus_state_e bus;
		logic [1:0] sel;
		logic aux;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [3:0] pinOut;
		logic [3:0] pinOe;
		logic rx;
	} top_s;

	top_s cur_ff;
	top_s nxt_cur;
	line_cfg_s cfg;
	logic [3:0] driveVal;
	logic [3:0] driveEn;
	logic [3:0] level;
	logic wrDir;
	logic wrInv;
	logic wrSrc;
	logic accessWr;

	// true when the address names a register
	function automatic logic isMapped(input logic [11:0] a);
		case (a)
			`OFS_LINE_INDEX_SELECT, `OFS_LINE_DIRECTION, `OFS_LINE_POLARITY_INVERT,
			`OFS_LINE_OUTPUT_SOURCE, `OFS_LINE_LEVEL, `OFS_ALL_LINE_LEVELS,
			`OFS_AUX_RAIL_ENABLE: isMapped = 1'b1;
			default: isMapped = 1'b0;
		endcase
	endfunction

	// outputs straight from flip-flops
	assign prdata = cur_ff.rdata;
	assign pready = cur_ff.ready;
	assign pslverr = cur_ff.err;
	assign lineOut = cur_ff.pinOut;
	assign lineOe = cur_ff.pinOe;
	assign serialRxData = cur_ff.rx;
	assign auxRailEnable = cur_ff.aux;

	// a write lands at the edge that ends the access phase (pready high), with byte 0 enabled
	assign accessWr = (cur_ff.bus == BUS_ACCESS) && psel && penable && pwrite && pstrb[0];
	assign wrDir = accessWr && (paddr == `OFS_LINE_DIRECTION);
	assign wrInv = accessWr && (paddr == `OFS_LINE_POLARITY_INVERT);
	assign wrSrc = accessWr && (paddr == `OFS_LINE_OUTPUT_SOURCE);

	line_cfg_store u_store (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.wrDir(wrDir),
		.wrInv(wrInv),
		.wrSrc(wrSrc),
		.sel(cur_ff.sel),
		.wdata(pwdata),
		.cfg(cfg)
	);

	line_drive u_drive (
		.cfg(cfg),
		.pinIn(lineIn),
		.sensorExposingFlag(sensorExposingFlag),
		.triggerReadyFlag(triggerReadyFlag),
		.serialTxSource(serialTxSource),
		.driveVal(driveVal),
		.driveEn(driveEn),
		.level(level)
	);

	// bus slave: setup cycle captures read data, one access cycle answers and commits writes
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.pinOut = driveVal;
		nxt_cur.pinOe = driveEn;
		nxt_cur.rx = level[1];
		nxt_cur.ready = 1'b0;
		nxt_cur.err = 1'b0;
		case (cur_ff.bus)
			BUS_IDLE: begin
				if (psel && !penable) begin
					nxt_cur.bus = BUS_ACCESS;
					nxt_cur.ready = 1'b1;
					nxt_cur.err = !isMapped(paddr);
					nxt_cur.rdata = 32'h0000_0000;
					if (!pwrite) begin
						// levels are sampled only at read time
						case (paddr)
							`OFS_LINE_INDEX_SELECT: nxt_cur.rdata[1:0] = cur_ff.sel;
							`OFS_LINE_DIRECTION: nxt_cur.rdata[0] = cfg.dirOut[cur_ff.sel];
							`OFS_LINE_POLARITY_INVERT: nxt_cur.rdata[0] = cfg.invert[cur_ff.sel];
							`OFS_LINE_OUTPUT_SOURCE: nxt_cur.rdata[2:0] = cfg.source[cur_ff.sel];
							`OFS_LINE_LEVEL: nxt_cur.rdata[0] = level[cur_ff.sel];
							`OFS_ALL_LINE_LEVELS: nxt_cur.rdata[3:0] = level;
							`OFS_AUX_RAIL_ENABLE: nxt_cur.rdata[0] = cur_ff.aux;
							default: nxt_cur.rdata = 32'h0000_0000;
						endcase
					end
				end
			end
			BUS_ACCESS: begin
				nxt_cur.bus = BUS_IDLE;
				// writes take effect only as the transfer completes
				if (accessWr && paddr == `OFS_LINE_INDEX_SELECT) begin
					nxt_cur.sel = pwdata[1:0];
				end
				if (accessWr && paddr == `OFS_AUX_RAIL_ENABLE) begin
					nxt_cur.aux = pwdata[0];
				end
			end
			default: begin
				nxt_cur.bus = BUS_IDLE;
			end
		endcase
	end

	// register the whole state; reset leaves pins undriven and rail off
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_ff.bus <= BUS_IDLE;
			cur_ff.sel <= `RST_SELECT;
			cur_ff.aux <= `RST_AUX_RAIL;
			cur_ff.rdata <= 32'h0000_0000;
			cur_ff.ready <= 1'b0;
			cur_ff.err <= 1'b0;
			cur_ff.pinOut <= 4'h0;
			cur_ff.pinOe <= 4'h0;
			cur_ff.rx <= 1'b0;
		end else if (ce) begin
			cur_ff <= nxt_cur;
		end
	end
endmodule

// >>> verif/line_partner.sv
// connector equipment: drives each line the device leaves alone
// assumes: lines with no driver read the equipment's own value
`timescale 1ns/10ps
module line_partner (
	input wire logic [3:0] lineOut, // device drive values
	input wire logic [3:0] lineOe, // device drive enables
	input wire logic [3:0] extDrive, // equipment values
	output logic [3:0] lineIn // resolved pin levels
);
	// the device wins where it drives
	assign lineIn = (lineOe & lineOut) | (~lineOe & extDrive);
endmodule

// >>> verif/gpio_line_chk_assertions.sv
// checker: bus answer, rail and enable side effects, reset state
// assumes: bound to the line controller top, byte offsets from the map
`timescale 1ns/10ps
`include "gpio_line_map.svh"
module gpio_line_chk (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic ce, // clock enable
	input wire logic psel, // select
	input wire logic penable, // enable
	input wire logic pwrite, // direction
	input wire logic [11:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [3:0] pstrb, // byte strobes
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [3:0] lineOe, // line enables
	input wire logic auxRailEnable // rail switch
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic wrSet;
	logic railWr;
	// write completing its access phase, and one with byte 0 aimed at the rail bit
	assign wrSet = psel && penable && pready && ce && pwrite;
	assign railWr = wrSet && pstrb[0] && paddr == `OFS_AUX_RAIL_ENABLE;
	sequence s_setup;
		psel && !penable && ce;
	endsequence
	sequence s_rail;
		railWr;
	endsequence
	property p_ready; s_setup |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_pulse; pready && ce |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("long ready");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_upper; pready && !pwrite |-> prdata[31:4] == '0; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_railSet; s_rail |=> auxRailEnable == $past(pwdata[0]); endproperty
	a_railSet: assert property (p_railSet) else $error("rail not set");
	property p_railHold; $changed(auxRailEnable) |-> $past(railWr); endproperty
	a_railHold: assert property (p_railHold) else $error("rail moved");
	property p_oe; !$stable(lineOe) |-> $past(wrSet, 2); endproperty
	a_oe: assert property (p_oe) else $error("enable moved");
	property p_reset; $fell(rst) |-> lineOe == '0 && !auxRailEnable; endproperty
	a_reset: assert property (p_reset) else $error("reset state");
endmodule

// >>> verif/camera_gpio_line_control_tb.sv
// testbench: line controller against a behavioural model
// assumes: apb master here, equipment model on the lines
`timescale 1ns/10ps
`include "gpio_line_map.svh"
module camera_gpio_line_control_tb;
	logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
	logic sensorExposingFlag = 0, triggerReadyFlag = 0, serialTxSource = 0, serialRxData, auxRailEnable;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r, rv, x;
	logic [3:0] pstrb = 4'hf, lineIn, lineOut, lineOe, ext = '0;
	int fails = 0, samples_checked = 0, inv[4], src, dir, n, lv;
	camera_gpio_line_control DUT (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.lineIn(lineIn),
		.lineOut(lineOut),
		.lineOe(lineOe),
		.sensorExposingFlag(sensorExposingFlag),
		.triggerReadyFlag(triggerReadyFlag),
		.serialTxSource(serialTxSource),
		.serialRxData(serialRxData),
		.auxRailEnable(auxRailEnable)
	);
	line_partner eq (.lineOut(lineOut), .lineOe(lineOe), .extDrive(ext), .lineIn(lineIn));
	// clock
	always #2 clk = ~clk;
	task automatic results;
		if (fails == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] t);
		samples_checked++;
		if (g !== t) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, t);
		end
	endtask
	// one apb transfer, waits for ready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge clk);
			k++;
		end
		// a missing answer counts as a mismatch
		if (pready !== 1'b1) begin
			chk(pready, 1);
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] t);
		apb(0, a, '0);
		chk(r, t);
	endtask
	// watchdog
	initial begin
		#40000;
		fails++;
		results();
	end
	// main sequence
	initial begin
		rv = $urandom(61238);
		repeat (10) @(posedge clk);
		rst <= 0;
		rd(`OFS_LINE_DIRECTION, 0);
		rd(`OFS_LINE_OUTPUT_SOURCE, 0);
		rd(`OFS_LINE_POLARITY_INVERT, 0);
		rd(`OFS_AUX_RAIL_ENABLE, 0);
		rd(`OFS_LINE_INDEX_SELECT, 0);
		for (int i = 0; i < 16; i++) begin
			n = i % 4;
			src = i % 8;
			dir = i % 3 != 0;
			rv = $urandom;
			inv[n] = rv[7];
			ext <= rv[3:0];
			sensorExposingFlag <= rv[4];
			triggerReadyFlag <= rv[5];
			serialTxSource <= rv[6];
			apb(1, `OFS_LINE_INDEX_SELECT, n);
			apb(1, `OFS_LINE_POLARITY_INVERT, inv[n]);
			apb(1, `OFS_LINE_OUTPUT_SOURCE, src);
			apb(1, `OFS_LINE_DIRECTION, dir);
			repeat (3) @(posedge clk);
			lv = src == 0 ? 0 : src < 5 ? rv[src-1] ^ inv[src-1] : rv[src-1];
			chk(lineOe, (dir && src) << n);
			if (dir && src) chk(lineOut[n], lv ^ inv[n]);
			for (int k = 0; k < 4; k++) x[k] = (k == n && dir && src) ? lv : rv[k] ^ inv[k];
			rd(`OFS_LINE_LEVEL, x[n]);
			rd(`OFS_ALL_LINE_LEVELS, x & 4'hf);
			apb(1, `OFS_LINE_DIRECTION, 0);
		end
		chk(serialRxData, rv[1] ^ inv[1]);
		// pins move while the clock enable is low: outputs stay frozen
		ce <= 0;
		ext <= ~ext;
		repeat (3) @(posedge clk);
		chk(serialRxData, rv[1] ^ inv[1]);
		ce <= 1;
		repeat (2) @(posedge clk);
		chk(serialRxData, rv[1] ^ inv[1] ^ 1);
		apb(1, `OFS_AUX_RAIL_ENABLE, 1);
		@(posedge clk);
		chk(auxRailEnable, 1);
		rd(`OFS_AUX_RAIL_ENABLE, 1);
		// a write without byte 0 enabled leaves the rail alone
		pstrb <= 4'h0;
		apb(1, `OFS_AUX_RAIL_ENABLE, 0);
		pstrb <= 4'hf;
		rd(`OFS_AUX_RAIL_ENABLE, 1);
		apb(0, 12'h01c, '0);
		chk(e, 1);
		chk(r, 0);
		apb(1, `OFS_AUX_RAIL_ENABLE, 0);
		rd(`OFS_AUX_RAIL_ENABLE, 0);
		results();
	end
endmodule
bind camera_gpio_line_control gpio_line_chk chk (
	.clk(clk),
	.rst(rst),
	.ce(ce),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pstrb(pstrb),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.lineOe(lineOe),
	.auxRailEnable(auxRailEnable)
);
